/* File: dv/cra_console_access_chk.sv */
// port checker for the console register access block
// assumes it is bound onto cra_console_access
`timescale 1ns/100ps
`default_nettype none
module cra_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic addr_clear,
    input wire logic addr_digit_valid,
    input wire logic [2:0] digit,
    input wire logic open_reg,
    input wire logic [2:0] reg_designator,
    input wire logic open_addr,
    input wire logic psw_write,
    input wire logic [15:0] psw_in,
    input wire logic bus_timeout,
    input wire logic parity_error,
    input wire logic proceed,
    input wire logic [21:0] addr_value,
    input wire logic [15:0] psw_value,
    input wire logic [3:0] reg_index,
    input wire logic reg_open_valid,
    input wire logic addr_open_valid,
    input wire logic resume,
    input wire logic tx_valid,
    input wire logic [7:0] tx_char,
    input wire logic err_busy
);
    logic [3:0] set_exp_reg;
    logic [21:0] addr_exp_reg;
    logic [15:0] psw_exp_reg;
    logic [23:0] addr_model_reg;
    // shadow of the address entry, built from the clear and digit strobes alone
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_model_reg <= 24'h00_0000;
        end else if (addr_clear) begin
            addr_model_reg <= 24'h00_0000;
        end else if (addr_digit_valid) begin
            addr_model_reg <= {addr_model_reg[20:0], digit};
        end
    end
    // expectations frozen at the request edge, judged one edge on
    always @(posedge clk) begin
        set_exp_reg <= {psw_value[11], reg_designator};
        addr_exp_reg <= addr_model_reg[21:0];
        psw_exp_reg <= (psw_in & 16'hffef) | (psw_value & 16'h0010);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_sp_kernel: assert property (
        open_reg && reg_designator == 3'h6 && psw_value[15:14] == 2'h0 && !err_busy
        |=> reg_open_valid && reg_index == 4'h6) else $error("kernel stack pick wrong");
    a_sp_user: assert property (
        open_reg && reg_designator == 3'h6 && psw_value[15:14] == 2'h3 && !err_busy
        |=> reg_open_valid && reg_index == 4'hf) else $error("user stack pick wrong");
    a_set_pick: assert property (
        open_reg && reg_designator < 3'h6 && !err_busy
        |=> reg_open_valid && reg_index == set_exp_reg) else $error("register set wrong");
    a_addr_shift: assert property (
        open_addr && !addr_model_reg[0] && !err_busy
        |=> addr_open_valid && addr_value == addr_exp_reg) else $error("address digit lost");
    a_odd_refused: assert property (
        open_addr && addr_model_reg[0] && !err_busy
        |=> !addr_open_valid && tx_valid && tx_char == 8'h3f) else $error("odd address taken");
    a_fault_err: assert property (
        (bus_timeout || parity_error) && !err_busy
        |=> tx_valid && tx_char == 8'h3f) else $error("fault gave no error");
    a_trace_kept: assert property (
        psw_write |=> psw_value == psw_exp_reg) else $error("status write wrong");
    a_resume_clean: assert property (
        proceed && !err_busy |=> resume && $stable(psw_value)) else $error("proceed wrong");
    c_prompt: cover property (tx_valid && tx_char == 8'h40);
    c_user_sp: cover property (reg_open_valid && reg_index == 4'hf);
    c_resume: cover property (resume);
endmodule
bind cra_console_access cra_chk u_chk (.clk, .reset_n, .addr_clear, .addr_digit_valid,
    .digit, .open_reg,
    .reg_designator, .open_addr, .psw_write, .psw_in, .bus_timeout, .parity_error, .proceed,
    .addr_value, .psw_value, .reg_index, .reg_open_valid, .addr_open_valid, .resume,
    .tx_valid, .tx_char, .err_busy);
`default_nettype wire

/* File: dv/cra_console_access_tb.sv */
// self-checking bench for the console register access block
// assumes the terminal model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "cra_defines.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
    $display("unexpected at %0t got %h exp %h", $time, g, e); fail_count++; end end
`define WAIT(c) begin k = 0; while (!(c) && k < 40) begin @(posedge clk); k++; end \
    if (!(c)) begin fail_count++; finish_test(); end end
module cra_console_access_tb;
    logic clk = 0, reset_n = 0, stall = 0, tx_ready, resume, tx_valid, err_busy;
    logic reg_open_valid, addr_open_valid;
    logic [9:0] ev = 10'h000;
    logic [2:0] digit = 3'h0, reg_designator = 3'h0;
    logic [15:0] psw_in = 16'h0000, psw_value, data_value;
    logic [21:0] addr_value;
    logic [3:0] reg_index;
    logic [7:0] tx_char;
    logic [7:0] ex [0:3] = '{`CRA_CH_QUEST, `CRA_CH_CR, `CRA_CH_LF, `CRA_CH_AT};
    int fail_count = 0, tests_run = 0, k, opens = 0;
    cra_console_access DUT (.clk, .reset_n, .addr_clear(ev[8]), .addr_digit_valid(ev[6]),
        .data_clear(ev[9]), .data_digit_valid(ev[7]), .digit, .open_reg(ev[4]),
        .reg_designator, .open_addr(ev[0]), .psw_write(ev[5]), .psw_in,
        .bus_timeout(ev[1]), .parity_error(ev[2]), .proceed(ev[3]), .tx_ready,
        .addr_value, .data_value, .psw_value, .reg_index, .reg_open_valid,
        .addr_open_valid, .resume, .tx_valid, .tx_char, .err_busy);
    cra_term term (.clk, .stall, .tx_valid, .tx_char, .tx_ready);
    initial forever #4 clk = ~clk;
    always @(posedge clk) opens <= opens + addr_open_valid;
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one-cycle strobe on event line i
    task pulse_ev(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev <= 10'h000;
    endtask
    task write_psw(input logic [15:0] v);
        psw_in <= v;
        pulse_ev(5);
        repeat (2) @(posedge clk);
    endtask
    task open_chk(input logic [2:0] d, input logic [3:0] e);
        reg_designator <= d;
        pulse_ev(4);
        `WAIT(reg_open_valid)
        `CHK(reg_index, e)
    endtask
    task t_stack;
        write_psw(16'h0000);
        open_chk(3'h6, 4'h6);
        write_psw(16'h4000);
        open_chk(3'h6, 4'he);
        write_psw(16'hc000);
        open_chk(3'h6, 4'hf);
        write_psw(16'h0000);
    endtask
    task t_regset;
        for (int i = 0; i < 12; i++) begin
            write_psw(i < 6 ? 16'h0800 : 16'h0000);
            open_chk(3'(i % 6), {i < 6, 3'(i % 6)});
        end
    endtask
    task t_trace;
        write_psw(16'hffff);
        `CHK(psw_value, 16'hffef)
        write_psw(16'h0000);
    endtask
    // digits 4,5,6,7,0,1,2,3,4 opened twice, then a 5 leaves the entry odd
    task t_entry;
        logic [23:0] ea;
        logic [17:0] ed;
        ea = 24'h00_0004;
        ed = 18'h0_0000;
        pulse_ev(8);
        digit <= 3'h4;
        pulse_ev(6);
        pulse_ev(0);
        `WAIT(addr_open_valid)
        `CHK(addr_value, 22'h00_0004)
        pulse_ev(9);
        for (int i = 1; i < 9; i++) begin
            digit <= 3'(i) ^ 3'h4;
            ea = {ea[20:0], 3'(i) ^ 3'h4};
            pulse_ev(6);
            pulse_ev(7);
            ed = {ed[14:0], 3'(i) ^ 3'h4};
        end
        pulse_ev(0);
        `WAIT(addr_open_valid)
        `CHK(addr_value, ea[21:0])
        `CHK(data_value, ed[15:0])
        digit <= 3'h5;
        pulse_ev(6);
    endtask
    // odd open with a stalling terminal, then bus timeout, then parity
    task t_err;
        int b, o;
        o = opens;
        for (int i = 0; i < 3; i++) begin
            b = term.n;
            stall <= (i == 0);
            pulse_ev(i);
            repeat (6) @(posedge clk);
            stall <= 1'b0;
            `WAIT(!err_busy && term.n == b + 4)
            for (int j = 0; j < 4; j++)
                `CHK(term.log_mem[b + j], ex[j])
        end
        `CHK(opens, o)
        digit <= 3'h2;
        pulse_ev(6);
        pulse_ev(0);
        `WAIT(addr_open_valid)
    endtask
    task t_proceed;
        write_psw(16'h8800);
        pulse_ev(3);
        `WAIT(resume)
        `CHK(psw_value, 16'h8800)
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_stack();
        t_regset();
        t_trace();
        t_entry();
        t_err();
        t_proceed();
        finish_test();
    end
endmodule
`default_nettype wire

/* File: dv/cra_term.sv */
// terminal model: takes each offered character while ready
// assumes the bench sets stall to play a slow terminal
`timescale 1ns/100ps
`default_nettype none
module cra_term (
    input wire logic clk,
    input wire logic stall,
    input wire logic tx_valid,
    input wire logic [7:0] tx_char,
    output logic tx_ready
);
    logic [7:0] log_mem [0:31];
    int n = 0;
    // ready drops while stalled, so the block must hold its character
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            log_mem[n[4:0]] <= tx_char;
            n <= n + 1;
        end
        tx_ready <= !stall;
    end
endmodule
`default_nettype wire

/* File: include/cra_defines.vh */
// constants for the console register access block
// assumes plain verilog-2005 and inclusion by bare name
`ifndef CRA_DEFINES_VH
`define CRA_DEFINES_VH
// ****************************************
// status word fields
// ****************************************
`define CRA_MODE_HI 15
`define CRA_MODE_LO 14
`define CRA_REGSET_BIT 11
`define CRA_TRACE_BIT 4
`define CRA_MODE_KERNEL 2'b00
`define CRA_MODE_SUPER 2'b01
`define CRA_MODE_USER 2'b11
// ****************************************
// entry widths in octal digits, bus widths in bits
// ****************************************
`define CRA_ADDR_DIGITS 8
`define CRA_DATA_DIGITS 6
`define CRA_ADDR_W 22
`define CRA_DATA_W 16
// ****************************************
// designator codes
// ****************************************
`define CRA_DSG_SP 3'h6
`define CRA_DSG_PC 3'h7
`define CRA_DSG_GR5 3'h5
// ****************************************
// ascii codes and status word reset value
// ****************************************
`define CRA_CH_QUEST 8'h3f
`define CRA_CH_CR 8'h0d
`define CRA_CH_LF 8'h0a
`define CRA_CH_AT 8'h40
`define CRA_PSW_RESET 16'h0000
`endif

/* File: src/cra_console_access.v */
// console register access: resolves designators, holds entries, flags errors
// assumes a character decoder upstream and a bus engine reporting timeouts
// Function
// - the stack designator opens the stack pointer picked by status word bits 15 to 14.
// - mode 00 picks the kernel stack pointer and mode 11 the user stack pointer.
// - an address entry keeps only its last eight octal digits.
// - a data entry keeps only its last six octal digits.
// - missing leading digits of an entry read as zeros.
// - an odd address is refused with question mark, return, line feed and prompt.
// - a bus timeout or parity error gives the same error response and prompt.
// - registers 0 to 5 use the set chosen by status word bit 11.
// - console writes to the status word leave the trace bit unchanged.
// - proceed resumes at the program counter and alters no visible state.
`timescale 1ns/100ps
`default_nettype none
`include "cra_defines.vh"
module cra_console_access (
    input wire clk,
    input wire reset_n,
    input wire addr_clear,
    input wire addr_digit_valid,
    input wire data_clear,
    input wire data_digit_valid,
    input wire [2:0] digit,
    input wire open_reg,
    input wire [2:0] reg_designator,
    input wire open_addr,
    input wire psw_write,
    input wire [15:0] psw_in,
    input wire bus_timeout,
    input wire parity_error,
    input wire proceed,
    input wire tx_ready,
    output reg [21:0] addr_value,
    output reg [15:0] data_value,
    output reg [15:0] psw_value,
    output reg [3:0] reg_index,
    output reg reg_open_valid,
    output reg addr_open_valid,
    output reg resume,
    output reg tx_valid,
    output reg [7:0] tx_char,
    output wire err_busy
);
    // ****************************************
    // reset release
    // ****************************************
    reg rst_meta_reg;
    reg rst_sync_reg;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rst_n = rst_sync_reg;
    // ****************************************
    // digit entries
    // ****************************************
    wire [23:0] addr_raw;
    wire [17:0] data_raw;
    // 8 octal digits = 24 bits, top two fall outside the 22-bit bus
    cra_octal_entry #(.WIDTH(3*`CRA_ADDR_DIGITS)) u_addr (
        .clk(clk),
        .rst_n(rst_n),
        .clear(addr_clear),
        .digit_valid(addr_digit_valid),
        .digit(digit),
        .value(addr_raw)
    );
    cra_octal_entry #(.WIDTH(3*`CRA_DATA_DIGITS)) u_data (
        .clk(clk),
        .rst_n(rst_n),
        .clear(data_clear),
        .digit_valid(data_digit_valid),
        .digit(digit),
        .value(data_raw)
    );
    // ****************************************
    // error response sequencer
    // ****************************************
    localparam ERR_IDLE = 3'd0;
    localparam ERR_Q = 3'd1;
    localparam ERR_CR = 3'd2;
    localparam ERR_LF = 3'd3;
    localparam ERR_AT = 3'd4;
    reg [2:0] err_state_reg;
    reg [2:0] err_state_next;
    wire odd_addr = open_addr && addr_raw[0];
    wire err_start = odd_addr || bus_timeout || parity_error;
    always @* begin
        err_state_next = err_state_reg;
        case (err_state_reg)
            ERR_IDLE: begin
                if (err_start) begin
                    err_state_next = ERR_Q;
                end
            end
            ERR_Q: begin
                if (tx_ready) begin
                    err_state_next = ERR_CR;
                end
            end
            ERR_CR: begin
                if (tx_ready) begin
                    err_state_next = ERR_LF;
                end
            end
            ERR_LF: begin
                if (tx_ready) begin
                    err_state_next = ERR_AT;
                end
            end
            ERR_AT: begin
                if (tx_ready) begin
                    err_state_next = ERR_IDLE;
                end
            end
            default: begin
                err_state_next = ERR_IDLE;
            end
        endcase
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_state_reg <= ERR_IDLE;
        end else begin
            err_state_reg <= err_state_next;
        end
    end
    // ****************************************
    // error character register
    // ****************************************
    // loaded from the next state so the flopped character lines up with tx_valid
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_char <= 8'h00;
        end else begin
            case (err_state_next)
                ERR_Q: tx_char <= `CRA_CH_QUEST;
                ERR_CR: tx_char <= `CRA_CH_CR;
                ERR_LF: tx_char <= `CRA_CH_LF;
                ERR_AT: tx_char <= `CRA_CH_AT;
                default: tx_char <= 8'h00;
            endcase
        end
    end
    // valid and busy are plain decodes of the state, handshake side
    always @* begin
        tx_valid = (err_state_reg != ERR_IDLE);
    end
    assign err_busy = (err_state_reg != ERR_IDLE);
    // ****************************************
    // designator resolution
    // ****************************************
    // index: 0-5 set 0, 8-13 set 1, 6 ksp, 7 pc, 14 ssp, 15 usp
    // read off the live status word, so a write one cycle earlier
    // is already in force when the designator opens
    reg [3:0] reg_index_next;
    always @* begin
        reg_index_next = {psw_value[`CRA_REGSET_BIT], reg_designator};
        if (reg_designator == `CRA_DSG_SP) begin
            case (psw_value[`CRA_MODE_HI:`CRA_MODE_LO])
                `CRA_MODE_KERNEL: reg_index_next = 4'h6;
                `CRA_MODE_USER: reg_index_next = 4'hf;
                `CRA_MODE_SUPER: reg_index_next = 4'he;
                default: reg_index_next = 4'he; // mode 10 shares the middle stack
            endcase
        end else if (reg_designator == `CRA_DSG_PC) begin
            reg_index_next = 4'h7;
        end
    end
    // ****************************************
    // status word
    // ****************************************
    // trace bit protected from console edits, a debugger may own it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            psw_value <= `CRA_PSW_RESET;
        end else if (psw_write) begin
            psw_value <= {psw_in[15:5], psw_value[`CRA_TRACE_BIT],
                          psw_in[3:0]};
        end
    end
    // ****************************************
    // open strobes and captured values
    // ****************************************
    // opens are dropped while an error reply is going out
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_index <= 4'h0;
            reg_open_valid <= 1'b0;
            addr_open_valid <= 1'b0;
            addr_value <= 22'h00_0000;
        end else begin
            reg_open_valid <= open_reg && !err_busy;
            addr_open_valid <= open_addr && !addr_raw[0] && !err_busy;
            if (open_reg && !err_busy) begin
                reg_index <= reg_index_next;
            end
            if (open_addr && !addr_raw[0] && !err_busy) begin
                addr_value <= addr_raw[21:0];
            end
        end
    end
    // data follows the entry one cycle late; proceed only echoes a strobe
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_value <= 16'h0000;
            resume <= 1'b0;
        end else begin
            data_value <= data_raw[15:0];
            resume <= proceed;
        end
    end
endmodule
`default_nettype wire

/* File: src/cra_octal_entry.v */
// octal digit accumulator for address or data entry
// assumes digits arrive as synchronous one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
module cra_octal_entry #(
    parameter WIDTH = 24
) (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire digit_valid,
    input wire [2:0] digit,
    output wire [WIDTH-1:0] value
);
    reg [WIDTH-1:0] value_reg;
    // ****************************************
    // shift register of digits
    // ****************************************
    // the oldest digit falls off the top, so only the newest are kept
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= {WIDTH{1'b0}};
        end else if (clear) begin
            value_reg <= {WIDTH{1'b0}}; // unsupplied digits read zero
        end else if (digit_valid) begin
            value_reg <= {value_reg[WIDTH-4:0], digit};
        end
    end
    assign value = value_reg;
endmodule
`default_nettype wire
